// ---- hw/aux_irq_ctrl.sv ----
/*
 * Auxiliary interrupt enable, status and pending index logic.
 * Assumes the core presents one-cycle register reads and writes on the system
 * clock and takes read data one cycle after the read strobe.
 */
//
// Functional notes
// - Enable bits 4 to 0 hold fast tick, serial tx, serial rx, analog low and core low.
// - Writing an enable bit loads its mask, zero masks the source and one enables it.
// - Reading the enable register returns the raw source states before masking.
// - Bit 0 merges core supply low and breakpoint and has the highest priority.
// - The eight-bit status register sits at A7h and resets to 00h.
// - A status flag is one only when its source is active and enabled.
// - The one-second flag at bit 7 is lowest priority and clears on a slow tick ack read.
// - The accumulator flag at bit 6 clears on a read of the summation low byte.
// - While the converter flag is set no new results are loaded, and a low byte read clears it.
// - The millisecond flag at bit 4 clears on a fast tick ack read.
// - The serial transmit flag at bit 3 clears on a write of the serial data register.
// - The serial receive flag at bit 2 clears on a read of the serial data register.
// - All auxiliary sources request service through the single vector 0033h.
// - A four-bit pending index names the highest-priority pending source, zero for none.
`timescale 1ns/10ps
`default_nettype none

module aux_irq_ctrl
	import aux_irq_pkg::*;
(
	input  wire logic         CLK,            // System clock, 200 MHz.
	input  wire logic         RESET_N,        // Asynchronous reset, active low.
	input  wire sfr_req_t     SFR_REQ,        // Register access from the core.
	output logic [7:0]        SFR_RDATA,      // Read data, valid after a read.
	input  wire aux_events_t  EVENTS,         // Event pulses from peripherals.
	input  wire logic         ANALOG_LOW_IN,  // Analog supply low level, async.
	input  wire logic         CORE_LOW_IN,    // Core supply low level, async.
	input  wire logic         BREAK_IN,       // Breakpoint hit level.
	input  wire logic         GLOBAL_EN,      // Auxiliary global enable.
	output logic              AUX_IRQ,        // Interrupt request to the core.
	output logic [15:0]       AUX_IRQ_VECTOR, // Service vector.
	output logic              CONV_LOAD_BLOCK // Stops new conversion results.
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]             enable_reg;
	logic [7:0]             raw_reg;
	logic [7:0]             raw_next;
	logic [7:0]             status_reg;
	logic [7:0]             status_next;
	logic [3:0]             pend_reg;
	logic [3:0]             pend_next;
	logic [7:0]             rdata_reg;
	logic [7:0]             rdata_next;
	logic                   irq_reg;
	logic                   irq_next;
	logic                   block_reg;
	logic [15:0]            vector_reg;
	logic [1:0]             ana_sync_reg;
	logic [1:0]             core_sync_reg;
	logic [NUM_LATCHED-1:0] ev_set;
	logic [NUM_LATCHED-1:0] ev_clr;
	logic [NUM_LATCHED-1:0] ev_q;
	logic                   rd_slow_ack;
	logic                   rd_fast_ack;
	logic                   rd_sum_low;
	logic                   rd_conv_low;
	logic                   rd_ser_data;
	logic                   wr_ser_data;
	logic                   wr_enable;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------

	// Side-effect strobes from accesses to neighbouring registers, and the enable register write strobe.
	assign rd_slow_ack = SFR_REQ.rd && (SFR_REQ.addr == SLOW_TICK_ACK_ADDR);
	assign rd_fast_ack = SFR_REQ.rd && (SFR_REQ.addr == FAST_TICK_ACK_ADDR);
	assign rd_sum_low  = SFR_REQ.rd && (SFR_REQ.addr == SUM_LOW_ADDR);
	assign rd_conv_low = SFR_REQ.rd && (SFR_REQ.addr == CONV_LOW_ADDR);
	assign rd_ser_data = SFR_REQ.rd && (SFR_REQ.addr == SERIAL_DATA_ADDR);
	assign wr_ser_data = SFR_REQ.wr && (SFR_REQ.addr == SERIAL_DATA_ADDR);
	assign wr_enable   = SFR_REQ.wr && (SFR_REQ.addr == AUX_ENABLE_ADDR);

	// ----------------------------------------------------------------
	// Event sources
	// ----------------------------------------------------------------

	// Event pulses by latch index, latch i serves source bit i+2.
	assign ev_set = {EVENTS.slow_tick, EVENTS.accum, EVENTS.conv,
		EVENTS.fast_tick, EVENTS.ser_tx, EVENTS.ser_rx};

	assign ev_clr[BIT_SLOW_TICK-2] = rd_slow_ack;
	assign ev_clr[BIT_ACCUM-2] = rd_sum_low;
	assign ev_clr[BIT_CONV-2] = rd_conv_low;
	assign ev_clr[BIT_FAST_TICK-2] = rd_fast_ack;
	assign ev_clr[BIT_SER_TX-2] = wr_ser_data;
	assign ev_clr[BIT_SER_RX-2] = rd_ser_data;

	// One sticky pending bit per event-driven source.
	generate
		for (genvar i = 0; i < NUM_LATCHED; i++) begin : g_latch
			aux_event_latch u_latch (
				.CLK     (CLK),
				.RESET_N (RESET_N),
				.SET     (ev_set[i]),
				.CLR     (ev_clr[i]),
				.Q       (ev_q[i])
			);
		end
	endgenerate

	// Supply detector levels arrive from outside the clock domain.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ana_sync_reg  <= 2'h0;
			core_sync_reg <= 2'h0;
		end else begin
			ana_sync_reg  <= {ana_sync_reg[0], ANALOG_LOW_IN};
			core_sync_reg <= {core_sync_reg[0], CORE_LOW_IN};
		end
	end

	assign raw_next = {ev_q, ana_sync_reg[1], core_sync_reg[1] | BREAK_IN};

	// ----------------------------------------------------------------
	// Enable, raw and status registers
	// ----------------------------------------------------------------

	assign status_next = raw_reg & enable_reg;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			enable_reg <= AUX_ENABLE_RESET;
		end else if (wr_enable) begin
			enable_reg <= SFR_REQ.wdata;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			raw_reg    <= AUX_STATUS_RESET;
			status_reg <= AUX_STATUS_RESET;
		end else begin
			raw_reg    <= raw_next;
			status_reg <= status_next;
		end
	end

	// ----------------------------------------------------------------
	// Pending index and request
	// ----------------------------------------------------------------

	// priority index
	// The loop runs from the lowest priority up so bit 0 is kept last.
	always_comb begin
		pend_next = PENDING_INDEX_RESET;
		for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
			if (status_reg[i]) begin
				pend_next = 4'(i + 1);
			end
		end
	end

	assign irq_next = (|status_reg) && GLOBAL_EN;

	// Registers the index, the request and the converter hold.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pend_reg   <= PENDING_INDEX_RESET;
			irq_reg    <= 1'b0;
			block_reg  <= 1'b0;
			vector_reg <= AUX_VECTOR;
		end else begin
			pend_reg   <= pend_next;
			irq_reg    <= irq_next;
			block_reg  <= status_reg[BIT_CONV];
			vector_reg <= AUX_VECTOR;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// raw read
	// Unmapped addresses read as zero.
	always_comb begin
		rdata_next = READ_DATA_RESET;
		if (SFR_REQ.addr == AUX_ENABLE_ADDR) begin
			rdata_next = raw_reg;
		end else if (SFR_REQ.addr == AUX_STATUS_ADDR) begin
			rdata_next = status_reg;
		end else if (SFR_REQ.addr == PENDING_INDEX_ADDR) begin
			rdata_next = {4'h0, pend_reg};
		end
	end

	// Captures read data on a read strobe and holds it until the next.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_reg <= READ_DATA_RESET;
		end else if (SFR_REQ.rd) begin
			rdata_reg <= rdata_next;
		end
	end

	assign SFR_RDATA       = rdata_reg;
	assign AUX_IRQ         = irq_reg;
	assign AUX_IRQ_VECTOR  = vector_reg;
	assign CONV_LOAD_BLOCK = block_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_enable_load: assert property (
		wr_enable |=> enable_reg == $past(SFR_REQ.wdata))
		else $error("enable register did not load written value");

	a_enable_hold: assert property (
		!wr_enable |=> $stable(enable_reg))
		else $error("enable register changed without a write");

	a_raw_read: assert property (
		SFR_REQ.rd && SFR_REQ.addr == AUX_ENABLE_ADDR |=> SFR_RDATA == $past(raw_reg))
		else $error("enable read did not return raw sources");

	a_status_mask: assert property (
		status_reg == ($past(raw_reg) & $past(enable_reg)))
		else $error("status is not raw AND enable");

	a_core_merge: assert property (
		BREAK_IN |=> raw_reg[BIT_CORE_LOW])
		else $error("breakpoint did not raise bit 0 source");

	a_slow_clear: assert property (
		rd_slow_ack && !EVENTS.slow_tick |=> ##1 !raw_reg[BIT_SLOW_TICK])
		else $error("slow tick source not cleared");

	a_accum_clear: assert property (
		rd_sum_low && !EVENTS.accum |=> ##1 !raw_reg[BIT_ACCUM])
		else $error("accumulator source not cleared");

	a_conv_clear: assert property (
		rd_conv_low && !EVENTS.conv |=> ##1 !raw_reg[BIT_CONV])
		else $error("converter source not cleared");

	a_fast_clear: assert property (
		rd_fast_ack && !EVENTS.fast_tick |=> ##1 !raw_reg[BIT_FAST_TICK])
		else $error("fast tick source not cleared");

	a_tx_clear: assert property (
		wr_ser_data && !EVENTS.ser_tx |=> ##1 !raw_reg[BIT_SER_TX])
		else $error("serial transmit source not cleared");

	a_rx_clear: assert property (
		rd_ser_data && !EVENTS.ser_rx |=> ##1 !raw_reg[BIT_SER_RX])
		else $error("serial receive source not cleared");

	a_set_wins: assert property (
		EVENTS.slow_tick && rd_slow_ack |=> ##1 raw_reg[BIT_SLOW_TICK])
		else $error("event lost during clear");

	a_conv_block: assert property (
		status_reg[BIT_CONV] |=> CONV_LOAD_BLOCK)
		else $error("converter hold not raised");

	a_pend_index: assert property (
		status_reg[BIT_CORE_LOW] |=> pend_reg == 4'h1)
		else $error("highest priority source not indexed");

	a_pend_none: assert property (
		status_reg == 8'h00 |=> pend_reg == 4'h0)
		else $error("index nonzero with nothing pending");

	a_irq_req: assert property (
		(|status_reg) && GLOBAL_EN |=> AUX_IRQ)
		else $error("request not raised");

	a_irq_gate: assert property (
		!GLOBAL_EN |=> !AUX_IRQ)
		else $error("request raised while globally disabled");

	a_vector: assert property (
		AUX_IRQ_VECTOR == AUX_VECTOR)
		else $error("service vector wrong");

	c_irq_raised: cover property (!AUX_IRQ ##1 AUX_IRQ);
	c_set_clear: cover property (EVENTS.slow_tick && rd_slow_ack);
	c_two_pending: cover property (status_reg[BIT_SER_RX] && status_reg[BIT_SLOW_TICK]);
	c_masked_raw: cover property (raw_reg[BIT_ANA_LOW] && !enable_reg[BIT_ANA_LOW]);

endmodule : aux_irq_ctrl

`default_nettype wire

// ---- hw/aux_irq_pkg.sv ----
/*
 * Constants and carrier types for the auxiliary interrupt enable and status block.
 * Assumes an eight-bit special function register bus from the processor core.
 */
`default_nettype none

package aux_irq_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] PENDING_INDEX_ADDR = 8'ha5;
	localparam logic [7:0] AUX_ENABLE_ADDR    = 8'ha6;
	localparam logic [7:0] AUX_STATUS_ADDR    = 8'ha7;
	localparam logic [7:0] SERIAL_DATA_ADDR   = 8'h9b;
	localparam logic [7:0] SLOW_TICK_ACK_ADDR = 8'hf9;
	localparam logic [7:0] FAST_TICK_ACK_ADDR = 8'hfa;
	localparam logic [7:0] SUM_LOW_ADDR       = 8'he2;
	localparam logic [7:0] CONV_LOW_ADDR      = 8'hd9;

	// ----------------------------------------------------------------
	// Source bit positions, bit 0 has the highest priority
	// ----------------------------------------------------------------
	localparam int BIT_SLOW_TICK = 7;
	localparam int BIT_ACCUM     = 6;
	localparam int BIT_CONV      = 5;
	localparam int BIT_FAST_TICK = 4;
	localparam int BIT_SER_TX    = 3;
	localparam int BIT_SER_RX    = 2;
	localparam int BIT_ANA_LOW   = 1;
	localparam int BIT_CORE_LOW  = 0;
	localparam int NUM_SOURCES   = 8;
	localparam int NUM_LATCHED   = 6;

	// ----------------------------------------------------------------
	// Reset values and the common vector
	// ----------------------------------------------------------------
	localparam logic [7:0]  AUX_ENABLE_RESET    = 8'h00;
	localparam logic [7:0]  AUX_STATUS_RESET    = 8'h00;
	localparam logic [3:0]  PENDING_INDEX_RESET = 4'h0;
	localparam logic [7:0]  READ_DATA_RESET     = 8'h00;
	localparam logic [15:0] AUX_VECTOR          = 16'h0033;

	// Register access request from the core.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// Event pulses from peripherals on the system clock.
	typedef struct packed {
		logic slow_tick;
		logic accum;
		logic conv;
		logic fast_tick;
		logic ser_tx;
		logic ser_rx;
	} aux_events_t;

endpackage : aux_irq_pkg

`default_nettype wire

// ---- hw/aux_event_latch.sv ----
/*
 * Sticky pending bit for one event-driven interrupt source.
 * Assumes set and clear are single-clock pulses on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module aux_event_latch (
	input  wire logic CLK,     // System clock.
	input  wire logic RESET_N, // Asynchronous reset, active low.
	input  wire logic SET,     // Source event pulse.
	input  wire logic CLR,     // Acknowledge access pulse.
	output logic      Q        // Pending state.
);

	// ----------------------------------------------------------------
	// Pending bit
	// ----------------------------------------------------------------
	logic q_reg;
	logic q_next;

	// A set in the clearing cycle wins so no event is lost.
	assign q_next = SET | (q_reg & ~CLR);

	// Holds the pending state.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q_reg <= 1'b0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign Q = q_reg;

endmodule : aux_event_latch

`default_nettype wire

// ---- bench/aux_core_model.sv ----
/*
 * Processor core model that issues register reads and writes to the block.
 * Assumes the block samples requests on the rising clock edge; the model drives at falling edges.
 */
`timescale 1ns/10ps
`default_nettype none

module aux_core_model
	import aux_irq_pkg::*;
(
	input  wire logic       CLK,       // System clock.
	output var  sfr_req_t   SFR_REQ,   // Register access to the block.
	input  wire logic [7:0] SFR_RDATA  // Read data from the block.
);

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------

	// The bus is idle at time zero.
	initial begin
		SFR_REQ = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00};
	end

	// One write pulse; a released bus shows inverted values so stale data never matches.
	// register write
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		SFR_REQ = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge CLK);
		SFR_REQ = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : sfr_wr

	// One read pulse, data taken a cycle and a half after the sampling edge.
	// register read
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge CLK);
		SFR_REQ = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge CLK);
		SFR_REQ = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
		@(negedge CLK);
		d = SFR_RDATA;
	endtask : sfr_rd

endmodule : aux_core_model

`default_nettype wire

// ---- bench/aux_interrupt_enable_status_tb_top.sv ----
/*
 * Self-checking testbench for the auxiliary interrupt enable and status block.
 * Assumes the core model drives the register bus and all other inputs change at falling edges.
 */
`timescale 1ns/10ps
`default_nettype none

module aux_interrupt_enable_status_tb_top;
	import aux_irq_pkg::*;

	logic        CLK = 1'b0;
	logic        RESET_N;
	sfr_req_t    SFR_REQ;
	logic [7:0]  SFR_RDATA;
	aux_events_t EVENTS;
	logic        ANALOG_LOW_IN;
	logic        CORE_LOW_IN;
	logic        BREAK_IN;
	logic        GLOBAL_EN;
	logic        AUX_IRQ;
	logic [15:0] AUX_IRQ_VECTOR;
	logic        CONV_LOAD_BLOCK;
	int          error_cnt = 0;
	int          num_checks = 0;
	logic [7:0]  rd_val;
	logic [7:0]  clr_addr [6] = '{SLOW_TICK_ACK_ADDR, SUM_LOW_ADDR, CONV_LOW_ADDR,
		FAST_TICK_ACK_ADDR, SERIAL_DATA_ADDR, SERIAL_DATA_ADDR};

	// 200 MHz system clock.
	always #2.5 CLK = ~CLK;

	aux_irq_ctrl dut (.CLK(CLK), .RESET_N(RESET_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
		.EVENTS(EVENTS), .ANALOG_LOW_IN(ANALOG_LOW_IN), .CORE_LOW_IN(CORE_LOW_IN),
		.BREAK_IN(BREAK_IN), .GLOBAL_EN(GLOBAL_EN), .AUX_IRQ(AUX_IRQ),
		.AUX_IRQ_VECTOR(AUX_IRQ_VECTOR), .CONV_LOAD_BLOCK(CONV_LOAD_BLOCK));

	aux_core_model core (.CLK(CLK), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		core.sfr_rd(a, rd_val);
		check(16'(rd_val), 16'(exp));
	endtask : rd_chk

	// Lets the sync, latch and status stages settle.
	task automatic settle;
		repeat (6) @(negedge CLK);
	endtask : settle

	task automatic pulse(input aux_events_t e);
		@(negedge CLK);
		EVENTS = e;
		@(negedge CLK);
		EVENTS = '0;
		settle();
	endtask : pulse

	task automatic results;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge CLK);
		error_cnt++;
		results();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		RESET_N = 1'b0;
		EVENTS = '0;
		ANALOG_LOW_IN = 1'b0;
		CORE_LOW_IN = 1'b0;
		BREAK_IN = 1'b0;
		GLOBAL_EN = 1'b0;
		repeat (10) @(negedge CLK);
		RESET_N = 1'b1;
		rd_chk(AUX_STATUS_ADDR, AUX_STATUS_RESET);
		rd_chk(PENDING_INDEX_ADDR, 8'h00);
		rd_chk(AUX_ENABLE_ADDR, 8'h00);
		rd_chk(8'h10, 8'h00);
		check(AUX_IRQ_VECTOR, AUX_VECTOR);
		check(16'(AUX_IRQ), 16'h0000);
		// each latched source set and cleared by its access
		GLOBAL_EN = 1'b1;
		core.sfr_wr(AUX_ENABLE_ADDR, 8'hff);
		for (int i = 0; i < 6; i++) begin
			pulse(aux_events_t'(6'h20 >> i));
			rd_chk(AUX_STATUS_ADDR, 8'h80 >> i);
			rd_chk(PENDING_INDEX_ADDR, 8'(8 - i));
			check(16'(AUX_IRQ), 16'h0001);
			check(16'(CONV_LOAD_BLOCK), 16'(i == 2));
			if (i == 4) begin
				core.sfr_wr(SERIAL_DATA_ADDR, 8'h5a);
			end else begin
				core.sfr_rd(clr_addr[i], rd_val);
			end
			settle();
			rd_chk(AUX_STATUS_ADDR, 8'h00);
			check(16'(AUX_IRQ), 16'h0000);
			check(16'(CONV_LOAD_BLOCK), 16'h0000);
		end
		// an event in its own clearing cycle wins
		fork
			core.sfr_rd(SLOW_TICK_ACK_ADDR, rd_val);
			pulse(aux_events_t'(6'h20));
		join
		rd_chk(AUX_STATUS_ADDR, 8'h80);
		core.sfr_rd(SLOW_TICK_ACK_ADDR, rd_val);
		settle();
		rd_chk(AUX_STATUS_ADDR, 8'h00);
		// slow tick loses to the accumulator
		pulse(aux_events_t'(6'h30));
		rd_chk(PENDING_INDEX_ADDR, 8'h07);
		core.sfr_rd(SUM_LOW_ADDR, rd_val);
		settle();
		rd_chk(PENDING_INDEX_ADDR, 8'h08);
		core.sfr_rd(SLOW_TICK_ACK_ADDR, rd_val);
		// masked source keeps its raw state
		core.sfr_wr(AUX_ENABLE_ADDR, 8'h00);
		pulse(aux_events_t'(6'h04));
		rd_chk(AUX_ENABLE_ADDR, 8'h10);
		rd_chk(AUX_STATUS_ADDR, 8'h00);
		check(16'(AUX_IRQ), 16'h0000);
		core.sfr_wr(AUX_ENABLE_ADDR, 8'h10);
		settle();
		rd_chk(AUX_STATUS_ADDR, 8'h10);
		check(16'(AUX_IRQ), 16'h0001);
		GLOBAL_EN = 1'b0;
		settle();
		check(16'(AUX_IRQ), 16'h0000);
		GLOBAL_EN = 1'b1;
		core.sfr_rd(FAST_TICK_ACK_ADDR, rd_val);
		// supply low levels and breakpoint merge
		core.sfr_wr(AUX_ENABLE_ADDR, 8'h03);
		ANALOG_LOW_IN = 1'b1;
		settle();
		rd_chk(AUX_STATUS_ADDR, 8'h02);
		rd_chk(PENDING_INDEX_ADDR, 8'h02);
		BREAK_IN = 1'b1;
		settle();
		rd_chk(AUX_STATUS_ADDR, 8'h03);
		rd_chk(PENDING_INDEX_ADDR, 8'h01);
		ANALOG_LOW_IN = 1'b0;
		BREAK_IN = 1'b0;
		CORE_LOW_IN = 1'b1;
		settle();
		rd_chk(AUX_STATUS_ADDR, 8'h01);
		rd_chk(AUX_ENABLE_ADDR, 8'h01);
		CORE_LOW_IN = 1'b0;
		// reset in mid-run clears flags and enables
		core.sfr_wr(AUX_ENABLE_ADDR, 8'hff);
		pulse(aux_events_t'(6'h01));
		rd_chk(AUX_STATUS_ADDR, 8'h04);
		RESET_N = 1'b0;
		repeat (3) @(negedge CLK);
		RESET_N = 1'b1;
		rd_chk(AUX_STATUS_ADDR, 8'h00);
		check(16'(AUX_IRQ), 16'h0000);
		pulse(aux_events_t'(6'h01));
		rd_chk(AUX_ENABLE_ADDR, 8'h04);
		rd_chk(AUX_STATUS_ADDR, 8'h00);
		results();
	end

endmodule : aux_interrupt_enable_status_tb_top

`default_nettype wire
